/* File: design/nps_core.sv */
/*
  Oscillator datapath: 32-bit phase accumulator, phase offset adder and sine table,
  feeding the 10-bit converter code every cycle.
  Assumes the word inputs are held by logic on core_clk_in; the select pins are
  asynchronous to it and are synchronised here.
*/
// Summary of operation
// - Phase lives in a 32-bit accumulator wrapping modulo two to the 32.
// - Each clock the accumulator adds the selected step to itself.
// - The step comes from one of two frequency words by current selection.
// - Frequency selection comes from a pin or a control bit.
// - Changing the selected word never resets or reloads the accumulator.
// - A 12-bit offset is added to the accumulator's top bits.
// - Four offset words; one LSB is one 4096th of a cycle.
// - The offset phase is cut to its upper 12 bits for addressing.
// - The truncated phase addresses a read-only sine table.
// - The table gives 10-bit codes from a 12-bit address.
// - The frequency select pin is sampled on rising clock edges.
// - The two phase select pins are sampled on rising clock edges.
// - Two select bits pick offset word zero to three, low bit weight one.
// - Selection low uses word a, high uses word b.
`timescale 1ns/10ps
module nps_core
  import nps_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic freq_word_select_in,
  input wire logic freq_select_bit_in,
  input wire logic freq_select_use_bit_in,
  input wire logic phase_offset_select_lo_in,
  input wire logic phase_offset_select_hi_in,
  input wire logic [1:0] phase_select_bits_in,
  input wire logic phase_select_use_bits_in,
  input wire nps_acc_t freq_step_word_a_in,
  input wire nps_acc_t freq_step_word_b_in,
  input wire nps_phase_t phase_offset_word0_in,
  input wire nps_phase_t phase_offset_word1_in,
  input wire nps_phase_t phase_offset_word2_in,
  input wire nps_phase_t phase_offset_word3_in,
  output nps_amp_t dac_code_out,
  output nps_acc_t phase_acc_out
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  // Each select pin passes three flops; a change counts once stages two and three agree.
  logic [2:0] fsel_sync_reg, fsel_sync_next;
  logic [2:0] psl_sync_reg, psl_sync_next;
  logic [2:0] psh_sync_reg, psh_sync_next;
  logic fsel_reg, fsel_next;
  logic [1:0] psel_reg, psel_next;
  nps_acc_t acc_reg, acc_next;
  nps_phase_t addr_reg, addr_next;
  logic fsel_eff;
  logic [1:0] psel_eff;
  nps_phase_t offset_sel;
  nps_acc_t step_sel;

  function automatic logic settle(input logic [2:0] sync, input logic held);
    settle = (sync[1] == sync[2]) ? sync[2] : held;
  endfunction : settle

  // One step picker serves the datapath; AST_ACC_STEP and AST_CONTINUOUS read its step_sel output.
  function automatic nps_acc_t pick_step(input logic sel, input nps_acc_t a, input nps_acc_t b);
    pick_step = sel ? b : a;
  endfunction : pick_step

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_comb begin
    fsel_sync_next = {fsel_sync_reg[1:0], freq_word_select_in};
    psl_sync_next = {psl_sync_reg[1:0], phase_offset_select_lo_in};
    psh_sync_next = {psh_sync_reg[1:0], phase_offset_select_hi_in};
    fsel_next = settle(fsel_sync_reg, fsel_reg);
    psel_next = {settle(psh_sync_reg, psel_reg[1]), settle(psl_sync_reg, psel_reg[0])};
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fsel_sync_reg <= 3'h0;
      psl_sync_reg <= 3'h0;
      psh_sync_reg <= 3'h0;
      fsel_reg <= 1'b0;
      psel_reg <= 2'h0;
    end else begin
      fsel_sync_reg <= fsel_sync_next;
      psl_sync_reg <= psl_sync_next;
      psh_sync_reg <= psh_sync_next;
      fsel_reg <= fsel_next;
      psel_reg <= psel_next;
    end
  end

  // The bit path bypasses the pin; the unused pin is expected tied low.
  assign fsel_eff = freq_select_use_bit_in ? freq_select_bit_in : fsel_reg;
  assign psel_eff = phase_select_use_bits_in ? phase_select_bits_in : psel_reg;

  always_comb begin
    case (psel_eff)
      2'h0: offset_sel = phase_offset_word0_in;
      2'h1: offset_sel = phase_offset_word1_in;
      2'h2: offset_sel = phase_offset_word2_in;
      default: offset_sel = phase_offset_word3_in;
    endcase
    // Word switching only changes the step; the accumulator keeps running.
    step_sel = pick_step(fsel_eff, freq_step_word_a_in, freq_step_word_b_in);
    acc_next = acc_reg + step_sel;
    // Lower accumulator bits are dropped; only the top 12 address the table.
    addr_next = acc_reg[`NPS_ACC_W-1 -: `NPS_PHASE_W] + offset_sel;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= `NPS_ACC_RESET;
      addr_reg <= `NPS_ADDR_RESET;
    end else begin
      acc_reg <= acc_next;
      addr_reg <= addr_next;
    end
  end

  nps_sine_rom nps_sine_rom_inst (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .addr_in(addr_reg),
    .amp_out(dac_code_out)
  );

  assign phase_acc_out = acc_reg;

  // Checked one edge later, since the value at the release edge was still forced by reset.
  AST_ACC_STEP: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    1'b1 |=> acc_reg == $past(acc_reg) + $past(step_sel))
    else $error("Accumulator did not advance by the selected step.");
  AST_SEL_A: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !fsel_eff |=> acc_reg == $past(acc_reg) + $past(freq_step_word_a_in))
    else $error("Select low did not use word a.");
  AST_SEL_B: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    fsel_eff |=> acc_reg == $past(acc_reg) + $past(freq_step_word_b_in))
    else $error("Select high did not use word b.");
  AST_CONTINUOUS: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $changed(fsel_eff) |=> acc_reg == $past(acc_reg) + $past(step_sel))
    else $error("Accumulator reloaded on frequency switch.");
  AST_ADDR: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    ##1 addr_reg == $past(acc_reg[31:20]) + $past(offset_sel))
    else $error("Table address is not top bits plus offset.");
  AST_OFFSET3: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psel_eff == 2'h3 |=> addr_reg == $past(acc_reg[31:20]) + $past(phase_offset_word3_in))
    else $error("Select three did not use offset word three.");
  AST_PIN_FSEL: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    fsel_sync_reg[2] == fsel_sync_reg[1] |=> fsel_reg == $past(fsel_sync_reg[2]))
    else $error("Settled frequency select not taken.");
  AST_PIN_PSEL: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psl_sync_reg[2] == psl_sync_reg[1] |=> psel_reg[0] == $past(psl_sync_reg[2]))
    else $error("Settled phase select not taken.");
  AST_BIT_SEL: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    freq_select_use_bit_in |-> fsel_eff == freq_select_bit_in)
    else $error("Control bit does not steer frequency selection.");
  AST_RESET_ZERO: assert property (@(posedge core_clk_in)
    !rst_n |-> acc_reg == `NPS_ACC_RESET)
    else $error("Accumulator not zero during reset.");

  // Every offset word is reached, so a swapped case item cannot hide.
  AST_OFFSET0: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psel_eff == 2'h0 |=> addr_reg == $past(acc_reg[31:20]) + $past(phase_offset_word0_in))
    else $error("Select zero did not use offset word zero.");

  AST_OFFSET1: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psel_eff == 2'h1 |=> addr_reg == $past(acc_reg[31:20]) + $past(phase_offset_word1_in))
    else $error("Select one did not use offset word one.");

  AST_OFFSET2: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psel_eff == 2'h2 |=> addr_reg == $past(acc_reg[31:20]) + $past(phase_offset_word2_in))
    else $error("Select two did not use offset word two.");

  AST_PIN_PSEL_HI: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psh_sync_reg[2] == psh_sync_reg[1] |=> psel_reg[1] == $past(psh_sync_reg[2]))
    else $error("Settled high phase select not taken.");

  // A pin still in flight must not move the selection; this is what bounds the uncertainty.
  AST_HOLD_FSEL: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    fsel_sync_reg[2] != fsel_sync_reg[1] |=> fsel_reg == $past(fsel_reg))
    else $error("Unsettled frequency select was taken.");

  AST_HOLD_PSEL_LO: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psl_sync_reg[2] != psl_sync_reg[1] |=> psel_reg[0] == $past(psel_reg[0]))
    else $error("Unsettled low phase select was taken.");

  AST_HOLD_PSEL_HI: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    psh_sync_reg[2] != psh_sync_reg[1] |=> psel_reg[1] == $past(psel_reg[1]))
    else $error("Unsettled high phase select was taken.");

  AST_PIN_STEER: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !freq_select_use_bit_in |-> fsel_eff == fsel_reg)
    else $error("Pin does not steer frequency selection.");

  AST_PSEL_STEER: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    phase_select_use_bits_in |-> psel_eff == phase_select_bits_in)
    else $error("Control bits do not steer offset selection.");

  AST_PSEL_PIN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !phase_select_use_bits_in |-> psel_eff == psel_reg)
    else $error("Pins do not steer offset selection.");

  // The converter code must also start from a known value, not only the accumulator.
  AST_RESET_ADDR: assert property (@(posedge core_clk_in)
    !rst_n |-> addr_reg == `NPS_ADDR_RESET && dac_code_out == `NPS_AMP_RESET)
    else $error("Address or code not cleared during reset.");

  AST_RESET_SEL: assert property (@(posedge core_clk_in)
    !rst_n |-> fsel_reg == 1'b0 && psel_reg == 2'h0)
    else $error("Settled selects not cleared during reset.");
endmodule : nps_core

/* File: design/nps_pkg.sv */
/*
  Types shared by the phase-to-sine core and its sine table.
  Assumes the constants header is on the include path.
*/
`include "nps_regs.svh"
package nps_pkg;
  typedef logic [`NPS_ACC_W-1:0] nps_acc_t;
  typedef logic [`NPS_PHASE_W-1:0] nps_phase_t;
  typedef logic [`NPS_AMP_W-1:0] nps_amp_t;
endpackage : nps_pkg

/* File: design/nps_regs.svh */
/*
  Constants for the phase-to-sine core: widths, reset values, table shape.
  Assumes it is included by bare name from the core package or modules.
*/
`ifndef NPS_REGS_SVH
`define NPS_REGS_SVH
`define NPS_ACC_W 32
`define NPS_PHASE_W 12
`define NPS_AMP_W 10
`define NPS_LUT_DEPTH 4096
`define NPS_ACC_RESET 32'h00000000
`define NPS_ADDR_RESET 12'h000
`define NPS_AMP_RESET 10'h000
`define NPS_AMP_MID 10'h200
`define NPS_AMP_HALF 10'h1FF
`endif

/* File: design/nps_sine_rom.sv */
/*
  Registered sine lookup table: 12-bit phase address to 10-bit offset-binary amplitude.
  Assumes an asynchronously asserted, synchronously released active-low reset from the core.
*/
`timescale 1ns/10ps
module nps_sine_rom
  import nps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire nps_phase_t addr_in,
  output nps_amp_t amp_out
);
  nps_amp_t amp_reg;
  nps_amp_t amp_next;
  nps_amp_t table_mem [`NPS_LUT_DEPTH];

  // The table is a constant filled at elaboration; it synthesises to logic.
  initial begin
    for (int i = 0; i < `NPS_LUT_DEPTH; i++) begin
      table_mem[i] = nps_amp_t'($rtoi(511.5 + 511.0 * $sin(6.283185307179586 * i / 4096.0)));
    end
  end

  always_comb begin
    amp_next = table_mem[addr_in];
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      amp_reg <= `NPS_AMP_RESET;
    end else begin
      amp_reg <= amp_next;
    end
  end

  assign amp_out = amp_reg;
endmodule : nps_sine_rom

/* File: dv/nps_core_tb_top.sv */
/*
  Self-checking bench for the phase-to-sine core and its converter model.
  Assumes all inputs are driven on falling edges, away from the sampling edge.
*/
`timescale 1ns/10ps
module nps_core_tb_top import nps_pkg::*;;
  logic clk = 1'b0, rst_b = 1'b1, fs_pin = 1'b0, fs_bit = 1'b0, fs_use = 1'b1;
  logic ps_lo = 1'b0, ps_hi = 1'b0, ps_use = 1'b1;
  logic [1:0] ps_bits = 2'h0;
  nps_acc_t wa = 32'h01234567, wb = 32'hF0000001, acc, cur, p1, p2;
  nps_phase_t ow[4] = '{12'h000, 12'h400, 12'h800, 12'hC55};
  nps_amp_t dac, lvl, dac_now, dac_q;
  int num_errors = 0, check_count = 0;
  always #5 clk = ~clk;
  nps_core nps_core_inst (.core_clk_in(clk), .rst_b_in(rst_b), .freq_word_select_in(fs_pin),
    .freq_select_bit_in(fs_bit), .freq_select_use_bit_in(fs_use),
    .phase_offset_select_lo_in(ps_lo), .phase_offset_select_hi_in(ps_hi),
    .phase_select_bits_in(ps_bits), .phase_select_use_bits_in(ps_use),
    .freq_step_word_a_in(wa), .freq_step_word_b_in(wb), .phase_offset_word0_in(ow[0]),
    .phase_offset_word1_in(ow[1]), .phase_offset_word2_in(ow[2]),
    .phase_offset_word3_in(ow[3]), .dac_code_out(dac), .phase_acc_out(acc));
  nps_dac_model nps_dac_model_inst (.clk_in(clk), .code_in(dac), .level_out(lvl));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Inputs change right after this falling edge, so selects never move at a rising edge.
  task tick(input int n);
    repeat (n) begin
      @(negedge clk);
      p2 = p1;
      p1 = cur;
      cur = acc;
      dac_q = dac_now;
      dac_now = dac;
    end
  endtask : tick
  function automatic nps_amp_t sine_of(input nps_phase_t a);
    return nps_amp_t'($rtoi(511.5 + 511.0 * $sin(6.283185307179586 * a / 4096.0)));
  endfunction : sine_of
  task run_reset;
    // A real falling edge, so the asynchronous reset branch sees an event.
    rst_b = 1'b0;
    tick(3);
    check(acc, 32'h00000000);
    check({22'h0, dac}, 32'h00000000);
    rst_b = 1'b1;
    tick(2);
    check(acc, 32'h00000000);
  endtask : run_reset
  task steps(input int n, input nps_acc_t s);
    repeat (n) begin
      tick(1);
      check(cur - p1, s);
    end
  endtask : steps
  task run_freq;
    steps(4, wa);
    fs_bit = 1'b1;
    steps(5, wb);
    fs_bit = 1'b0;
    steps(3, wa);
    fs_use = 1'b0;
    fs_pin = 1'b1;
    // The pin path is synchronised, so the switch cycle is only bounded, never exact.
    repeat (6) begin
      tick(1);
      check(32'((cur - p1 === wa) || (cur - p1 === wb)), 32'h1);
    end
    steps(4, wb);
  endtask : run_freq
  task run_offset(input logic use_bits);
    ps_use = use_bits;
    for (int s = 0; s < 4; s++) begin
      ps_bits = 2'(s);
      {ps_hi, ps_lo} = 2'(s);
      tick(6);
      repeat (3) begin
        tick(1);
        check({22'h0, dac}, {22'h0, sine_of(p2[31:20] + ow[s])});
        check({22'h0, lvl}, {22'h0, dac_q});
      end
    end
  endtask : run_offset
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end
  initial begin
    run_reset();
    run_freq();
    run_offset(1'b1);
    run_offset(1'b0);
    print_verdict();
  end
endmodule : nps_core_tb_top

/* File: dv/nps_dac_model.sv */
/*
  Behavioural converter at the core's far side: holds the latest amplitude code.
  Assumes codes arrive on the core clock and settle after its rising edge.
*/
`timescale 1ns/10ps
module nps_dac_model
  import nps_pkg::*;
(
  input wire logic clk_in,
  input wire nps_amp_t code_in,
  output nps_amp_t level_out
);
  // The converter latches a fresh code on every rising edge, since the core gives one per cycle.
  always_ff @(posedge clk_in) begin
    level_out <= code_in;
  end
endmodule : nps_dac_model
